// [core/brc_top.sv]
// buck regulator digital control: serial slave, setpoints, ramp, fault sequencing, power good
//
// Behaviour
// - select pin picks low or high setpoint
// - base group: 0.60 V plus code times 10 mV
// - fine group: 0.603 V plus code times 12.826 mV
// - raised group: 0.80 V plus code times 10 mV
// - 12.5 mV group: 0.60 V plus 12.5 mV steps
// - 12.967 mV group: 0.603 V plus 12.967 mV steps
// - reset loads option default setpoint codes
// - slew code halves rate from 64 mV/us
// - downward change stops switching until output reached
// - slew scaled by step ratio to 10 mV
// - undervoltage lockout holds off regulation while enabled
// - filtered input overvoltage stops switching
// - power good low when disabled or soft-starting
// - power good stays high during written transitions
// - limit turns high side off; sixteen cause retry
// - over-temperature disables switching until it clears
// - status reads 80 hex while regulating
// - data pulled low only for ack/read; MSB first
// - answer to address C0, or C4 alternate
// - sample on rising clock, change while low
// - master code enters high speed without a repeated start; stop leaves it
// - output on only with enable and selected bit
`timescale 1ns/100ps
`default_nettype none

module brc_top
  import brc_pkg::*;
#(
  parameter brc_group_t OPTION_GROUP = GRP_BASE,
  parameter logic       ALT_ADDRESS  = 1'b0,
  parameter int         RETRY_CYCLES = RETRY_OFF_CYC
)
(
  input  wire logic        clock,            // 10 MHz system clock
  input  wire logic        rst_n,            // power-on reset, active low
  input  wire brc_pins_t   pins,             // asynchronous pin and analog inputs
  output logic             sda_out,          // data line output level
  output logic             sda_oe,           // data line pulled while high
  output logic             power_ok_pin_out, // power good output level
  output logic             power_ok_pin_oe,  // power good pulled low while high
  output logic             switch_enable,    // modulator may switch
  output logic             high_side_off,    // force high-side switch off
  output logic             discharge_en,     // output discharge load on
  output logic             forced_pwm,       // forced PWM mode of selected setpoint
  output logic [20:0]      target_uv,        // ramped reference in microvolts
  output logic             hs_mode           // high-speed mode entered
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [PINS_W-1:0] sync1;
  logic [PINS_W-1:0] sync2;
  logic [PINS_W-1:0] sync3;
  logic [PINS_W-1:0] agreed;
  brc_pins_t         pin_s;

  // a change counts only once stages two and three agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1  <= PINS_RESET;
      sync2  <= PINS_RESET;
      sync3  <= PINS_RESET;
      agreed <= PINS_RESET;
    end
    else
    begin
      sync1  <= pins;
      sync2  <= sync1;
      sync3  <= sync2;
      agreed <= (sync2 & sync3) | (agreed & (sync2 | sync3));
    end
  end
  assign pin_s = brc_pins_t'(agreed);

  logic scl_q;
  logic sda_q;
  logic tick_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      tick_q <= 1'b0;
    end
    else
    begin
      scl_q  <= pin_s.scl;
      sda_q  <= pin_s.sda;
      tick_q <= pin_s.switch_cycle;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic tick_rise;
  assign scl_rise  = pin_s.scl & ~scl_q;
  assign scl_fall  = ~pin_s.scl & scl_q;
  assign bus_start = pin_s.scl & scl_q & sda_q & ~pin_s.sda;
  assign bus_stop  = pin_s.scl & scl_q & ~sda_q & pin_s.sda;
  assign tick_rise = pin_s.switch_cycle & ~tick_q;

  // ************************************************************
  // serial slave
  // ************************************************************
  localparam logic [7:0] OWN_ADDR = ALT_ADDRESS ? SLAVE_ADDR_ALT : SLAVE_ADDR_DEFAULT;

  brc_state_t state;
  brc_state_t after_ack;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic       master_nack;
  logic [7:0] rd_data;
  logic       wr_stb;
  logic [7:0] setpoint_reg_low;
  logic [7:0] setpoint_reg_high;
  logic [7:0] control;
  logic [7:0] regulation_status;

  always_comb
  begin
    if (ptr == REG_SETPOINT_LOW)
      rd_data = setpoint_reg_low;
    else if (ptr == REG_SETPOINT_HIGH)
      rd_data = setpoint_reg_high;
    else if (ptr == REG_CONTROL)
      rd_data = control;
    else if (ptr == REG_REGULATION)
      rd_data = regulation_status;
    else
      rd_data = UNMAPPED_READ;
  end

  assign wr_stb  = scl_fall & ~bus_start & ~bus_stop & (state == ST_WDATA) & (bitcnt == BITS_PER_BYTE);
  assign sda_out = 1'b0;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state       <= ST_IDLE;
      after_ack   <= ST_IDLE;
      bitcnt      <= 4'h0;
      shreg       <= 8'h00;
      txreg       <= 8'h00;
      ptr         <= 8'h00;
      master_nack <= 1'b1;
      sda_oe      <= 1'b0;
      hs_mode     <= 1'b0;
    end
    else if (bus_start)
    begin
      state  <= ST_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state   <= ST_IDLE;
      sda_oe  <= 1'b0;
      hs_mode <= 1'b0;
    end
    else if (scl_rise)
    begin
      // sampled on the rising edge, MSB first
      if (state == ST_ADDR || state == ST_REG || state == ST_WDATA)
      begin
        shreg  <= {shreg[6:0], pin_s.sda};
        bitcnt <= bitcnt + 4'h1;
      end
      if (state == ST_RACK)
        master_nack <= pin_s.sda;
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR:
          if (bitcnt == BITS_PER_BYTE)
          begin
            if (shreg[7:1] == OWN_ADDR[7:1])
            begin
              sda_oe    <= 1'b1;
              state     <= ST_ACK;
              after_ack <= shreg[0] ? ST_RDATA : ST_REG;
            end
            else if (shreg[7:3] == MASTER_CODE_TOP)
            begin
              // master code is never acknowledged
              hs_mode <= 1'b1;
              state   <= ST_IDLE;
            end
            else
              state <= ST_IDLE;
          end
        ST_REG:
          if (bitcnt == BITS_PER_BYTE)
          begin
            ptr       <= shreg;
            sda_oe    <= 1'b1;
            state     <= ST_ACK;
            after_ack <= ST_WDATA;
          end
        ST_WDATA:
          if (bitcnt == BITS_PER_BYTE)
          begin
            ptr       <= ptr + 8'h01;
            sda_oe    <= 1'b1;
            state     <= ST_ACK;
            after_ack <= ST_WDATA;
          end
        ST_ACK:
        begin
          bitcnt <= 4'h0;
          if (after_ack == ST_RDATA)
          begin
            txreg  <= rd_data;
            ptr    <= ptr + 8'h01;
            sda_oe <= ~rd_data[7];
            bitcnt <= 4'h1;
            state  <= ST_RDATA;
          end
          else
          begin
            sda_oe <= 1'b0;
            state  <= after_ack;
          end
        end
        ST_RDATA:
          if (bitcnt == BITS_PER_BYTE)
          begin
            sda_oe <= 1'b0;
            state  <= ST_RACK;
          end
          else
          begin
            sda_oe <= ~txreg[6];
            txreg  <= {txreg[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        ST_RACK:
          if (master_nack)
            state <= ST_IDLE;
          else
          begin
            txreg  <= rd_data;
            ptr    <= ptr + 8'h01;
            sda_oe <= ~rd_data[7];
            bitcnt <= 4'h1;
            state  <= ST_RDATA;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  localparam logic [7:0] DEF_LOW  = brc_default(OPTION_GROUP, 0);
  localparam logic [7:0] DEF_HIGH = brc_default(OPTION_GROUP, 1);
  localparam logic [7:0] DEF_CTRL = brc_default(OPTION_GROUP, 2);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setpoint_reg_low  <= DEF_LOW;
      setpoint_reg_high <= DEF_HIGH;
      control           <= DEF_CTRL;
    end
    else if (wr_stb)
    begin
      if (ptr == REG_SETPOINT_LOW)
        setpoint_reg_low <= shreg;
      else if (ptr == REG_SETPOINT_HIGH)
        setpoint_reg_high <= shreg;
      else if (ptr == REG_CONTROL)
        control <= shreg;
    end
  end

  // ************************************************************
  // enables and faults
  // ************************************************************
  logic [5:0]  voltage_code_field;
  logic        software_output_enable;
  logic [4:0]  ovp_cnt;
  logic        ovp_filtered;
  logic [4:0]  cl_cnt;
  logic        retry_off;
  logic [14:0] retry_cnt;
  logic        regulator_on;
  logic        down_wait;

  assign voltage_code_field     = pin_s.setpoint_select_pin ? setpoint_reg_high[CODE_MSB:0]
                                                            : setpoint_reg_low[CODE_MSB:0];
  assign software_output_enable = pin_s.setpoint_select_pin ? setpoint_reg_high[SW_ENABLE_BIT]
                                                            : setpoint_reg_low[SW_ENABLE_BIT];
  assign regulator_on = pin_s.hw_enable & software_output_enable
                      & ~pin_s.input_undervoltage_lockout
                      & ~ovp_filtered & ~pin_s.over_temperature
                      & ~retry_off;

  // spikes shorter than the filter never reach the shutdown
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovp_cnt      <= 5'h00;
      ovp_filtered <= 1'b0;
    end
    else if (!pin_s.input_overvoltage_guard)
    begin
      ovp_cnt      <= 5'h00;
      ovp_filtered <= 1'b0;
    end
    else if (ovp_cnt == 5'(OVP_FILTER_CYC - 1))
      ovp_filtered <= 1'b1;
    else
      ovp_cnt <= ovp_cnt + 5'h01;
  end

  // limit cycles counted per switching cycle; a clean cycle restarts the count
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cl_cnt    <= 5'h00;
      retry_off <= 1'b0;
      retry_cnt <= 15'h0000;
    end
    else if (retry_off)
    begin
      cl_cnt <= 5'h00;
      if (retry_cnt == 15'h0000)
        retry_off <= 1'b0;
      else
        retry_cnt <= retry_cnt - 15'h0001;
    end
    else if (tick_rise)
    begin
      if (!pin_s.current_limit)
        cl_cnt <= 5'h00;
      else if (cl_cnt == 5'(CL_CYCLES_LIMIT - 1))
      begin
        retry_off <= 1'b1;
        retry_cnt <= 15'(RETRY_CYCLES - 1);
        cl_cnt    <= 5'h00;
      end
      else
        cl_cnt <= cl_cnt + 5'h01;
    end
  end

  // ************************************************************
  // setpoint ramp
  // ************************************************************
  logic [19:0] ref_acc;
  logic [19:0] tgt_acc;
  logic [19:0] ramp_inc;
  logic [20:0] ramp_sum;
  logic [5:0]  ref_code;

  assign tgt_acc  = {voltage_code_field, 14'h0000};
  assign ref_code = ref_acc[19:RAMP_FRAC];
  assign ramp_inc = 20'(RAMP_INC0) >> control[SLEW_MSB:SLEW_LSB];
  assign ramp_sum = {1'b0, ref_acc} + {1'b0, ramp_inc};

  // an output-reached level left high from earlier ends the wait at once
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_acc   <= {DEF_LOW[CODE_MSB:0], 14'h0000};
      down_wait <= 1'b0;
    end
    else if (!regulator_on)
    begin
      ref_acc   <= tgt_acc;
      down_wait <= 1'b0;
    end
    else if (voltage_code_field < ref_code)
    begin
      down_wait <= ~pin_s.output_reached;
      if (pin_s.output_reached)
        ref_acc <= tgt_acc;
    end
    else
    begin
      down_wait <= 1'b0;
      if (ramp_sum >= {1'b0, tgt_acc})
        ref_acc <= tgt_acc;
      else
        ref_acc <= ramp_sum[19:0];
    end
  end

  function automatic logic [20:0] code_to_uv(input logic [5:0] code);
    logic [20:0] c;
    c = {15'h0000, code};
    case (OPTION_GROUP)
      GRP_BASE:     code_to_uv = 21'(OFFSET_600_UV) + c * 21'(STEP_10_UV);
      GRP_FINE:     code_to_uv = 21'(OFFSET_603_UV) + c * 21'(STEP_12826_UV);
      GRP_RAISED:   code_to_uv = 21'(OFFSET_800_UV) + c * 21'(STEP_10_UV);
      GRP_STEP_125: code_to_uv = 21'(OFFSET_600_UV) + c * 21'(STEP_12500_UV);
      default:      code_to_uv = 21'(OFFSET_603_UV) + c * 21'(STEP_12967_UV);
    endcase
  endfunction

  // ************************************************************
  // outputs and status
  // ************************************************************
  logic regulating;
  assign regulating = regulator_on & ~pin_s.soft_start & ~down_wait;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      switch_enable     <= 1'b0;
      high_side_off     <= 1'b1;
      power_ok_pin_oe   <= 1'b1;
      discharge_en      <= 1'b0;
      forced_pwm        <= 1'b0;
      target_uv         <= 21'h000000;
      regulation_status <= STATUS_IDLE;
    end
    else
    begin
      switch_enable     <= regulator_on & ~down_wait;
      high_side_off     <= pin_s.current_limit | ~regulator_on;
      // ramps do not touch power good
      power_ok_pin_oe   <= ~(regulator_on & ~pin_s.soft_start);
      discharge_en      <= control[DISCHARGE_BIT] & ~(pin_s.hw_enable & software_output_enable);
      forced_pwm        <= pin_s.setpoint_select_pin ? setpoint_reg_high[FORCE_PWM_BIT]
                                                     : setpoint_reg_low[FORCE_PWM_BIT];
      target_uv         <= code_to_uv(ref_code);
      regulation_status <= regulating ? STATUS_REGULATING : STATUS_IDLE;
    end
  end
  assign power_ok_pin_out = 1'b0;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_sel_code;
    @(posedge clock) disable iff (!rst_n)
    pin_s.setpoint_select_pin |-> voltage_code_field == setpoint_reg_high[CODE_MSB:0];
  endproperty
  a_sel_code: assert property (p_sel_code) else $error("high setpoint not selected");

  property p_target_map;
    @(posedge clock) disable iff (!rst_n)
    rst_n |=> target_uv == code_to_uv($past(ref_code));
  endproperty
  a_target_map: assert property (p_target_map) else $error("target voltage mismatch");

  property p_ramp_up;
    @(posedge clock) disable iff (!rst_n)
    (regulator_on && voltage_code_field > ref_code && $stable(voltage_code_field))
      |=> ref_acc > $past(ref_acc);
  endproperty
  a_ramp_up: assert property (p_ramp_up) else $error("ramp did not advance");

  property p_down_stop;
    @(posedge clock) disable iff (!rst_n)
    down_wait |=> !switch_enable;
  endproperty
  a_down_stop: assert property (p_down_stop) else $error("switching during downward wait");

  property p_input_undervoltage_lockout;
    @(posedge clock) disable iff (!rst_n)
    (pin_s.hw_enable && pin_s.input_undervoltage_lockout) |=> !switch_enable;
  endproperty
  a_input_undervoltage_lockout: assert property (p_input_undervoltage_lockout) else $error("switching under lockout");

  property p_ovp_filter;
    @(posedge clock) disable iff (!rst_n)
    $rose(ovp_filtered) |-> $past(pin_s.input_overvoltage_guard, 19);
  endproperty
  a_ovp_filter: assert property (p_ovp_filter) else $error("overvoltage not filtered");

  property p_power_ok_pin_off;
    @(posedge clock) disable iff (!rst_n)
    (!pin_s.hw_enable || pin_s.soft_start) |=> power_ok_pin_oe;
  endproperty
  a_power_ok_pin_off: assert property (p_power_ok_pin_off) else $error("power good high while off");

  // switch_enable is registered, so it follows retry_off one clock later
  property p_retry_hold;
    @(posedge clock) disable iff (!rst_n)
    $rose(retry_off) |=> (retry_off && !switch_enable) [*8];
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("retry off period cut short");

  property p_otp;
    @(posedge clock) disable iff (!rst_n)
    pin_s.over_temperature |=> !switch_enable;
  endproperty
  a_otp: assert property (p_otp) else $error("switching while hot");

  property p_status;
    @(posedge clock) disable iff (!rst_n)
    regulating |=> regulation_status == 8'h80;
  endproperty
  a_status: assert property (p_status) else $error("status not 80 while regulating");

  property p_sda_drive;
    @(posedge clock) disable iff (!rst_n)
    sda_oe |-> (state == ST_ACK || state == ST_RDATA);
  endproperty
  a_sda_drive: assert property (p_sda_drive) else $error("data line pulled outside ack or read");

  property p_addr_miss;
    @(posedge clock) disable iff (!rst_n)
    (scl_fall && !bus_start && !bus_stop && state == ST_ADDR && bitcnt == BITS_PER_BYTE
      && shreg[7:1] != OWN_ADDR[7:1]) |=> !sda_oe;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acknowledged");

  c_write: cover property (@(posedge clock) disable iff (!rst_n) wr_stb);
  c_read:  cover property (@(posedge clock) disable iff (!rst_n) state == ST_RACK);
  c_retry: cover property (@(posedge clock) disable iff (!rst_n) $rose(retry_off));
  c_down:  cover property (@(posedge clock) disable iff (!rst_n) $fell(down_wait));

endmodule // brc_top

`default_nettype wire

// [core/brc_pkg.sv]
// constants, types and defaults for the buck regulator serial control block
package brc_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int RETRY_OFF_US    = 1700;
  localparam int RETRY_OFF_CYC   = (RETRY_OFF_US * 1000) / CLK_PERIOD_NS;
  localparam int OVP_FILTER_NS   = 2000;
  localparam int OVP_FILTER_CYC  = (OVP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CL_CYCLES_LIMIT = 16;

  // ************************************************************
  // register map and fields
  // ************************************************************
  localparam logic [7:0] REG_SETPOINT_LOW  = 8'h00;
  localparam logic [7:0] REG_SETPOINT_HIGH = 8'h01;
  localparam logic [7:0] REG_CONTROL       = 8'h02;
  localparam logic [7:0] REG_REGULATION    = 8'h05;
  localparam int SW_ENABLE_BIT = 7;
  localparam int FORCE_PWM_BIT = 6;
  localparam int CODE_MSB      = 5;
  localparam int DISCHARGE_BIT = 7;
  localparam int SLEW_MSB      = 6;
  localparam int SLEW_LSB      = 4;
  localparam logic [7:0] STATUS_REGULATING = 8'h80;
  localparam logic [7:0] STATUS_IDLE       = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ************************************************************
  // serial link
  // ************************************************************
  localparam logic [7:0] SLAVE_ADDR_DEFAULT = 8'hC0;
  localparam logic [7:0] SLAVE_ADDR_ALT     = 8'hC4;
  localparam logic [4:0] MASTER_CODE_TOP    = 5'h01;
  localparam logic [3:0] BITS_PER_BYTE      = 4'h8;

  // ************************************************************
  // voltage code mapping, in microvolts
  // ************************************************************
  typedef enum logic [2:0] {
    GRP_BASE     = 3'h0,
    GRP_FINE     = 3'h1,
    GRP_RAISED   = 3'h2,
    GRP_STEP_125 = 3'h3,
    GRP_STEP_130 = 3'h4
  } brc_group_t;
  localparam int OFFSET_600_UV  = 600000;
  localparam int OFFSET_603_UV  = 603000;
  localparam int OFFSET_800_UV  = 800000;
  localparam int STEP_10_UV     = 10000;
  localparam int STEP_12826_UV  = 12826;
  localparam int STEP_12500_UV  = 12500;
  localparam int STEP_12967_UV  = 12967;

  // ramp step per clock in 1/2^RAMP_FRAC code units; code units make the step ratio scaling implicit
  localparam int FASTEST_SLEW_MV_PER_US = 64;
  localparam int RAMP_FRAC = 14;
  localparam int RAMP_INC0 = (FASTEST_SLEW_MV_PER_US * CLK_PERIOD_NS * (1 << RAMP_FRAC)) / STEP_10_UV;

  // ************************************************************
  // power-on defaults: index 0 low setpoint, 1 high setpoint, 2 control
  // ************************************************************
  function automatic logic [7:0] brc_default(input brc_group_t grp, input int idx);
    logic [7:0] v;
    v = 8'h00;
    case (grp)
      GRP_BASE:     v = (idx == 0) ? 8'hAD : (idx == 1) ? 8'hFC : 8'h80;
      GRP_FINE:     v = (idx == 0) ? 8'hA7 : (idx == 1) ? 8'hEF : 8'h80;
      GRP_RAISED:   v = (idx == 0) ? 8'hA3 : (idx == 1) ? 8'hA3 : 8'hB0;
      GRP_STEP_125: v = (idx == 0) ? 8'hAC : (idx == 1) ? 8'hAC : 8'hB0;
      default:      v = (idx == 0) ? 8'hB0 : (idx == 1) ? 8'hAF : 8'h80;
    endcase
    return v;
  endfunction

  // ************************************************************
  // carriers and states
  // ************************************************************
  typedef struct packed {
    logic scl;
    logic sda;
    logic hw_enable;
    logic setpoint_select_pin;
    logic input_undervoltage_lockout;
    logic input_overvoltage_guard;
    logic over_temperature;
    logic current_limit;
    logic switch_cycle;
    logic soft_start;
    logic output_reached;
  } brc_pins_t;
  localparam int PINS_W = $bits(brc_pins_t);
  localparam logic [PINS_W-1:0] PINS_RESET = 11'h600;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_REG   = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } brc_state_t;

endpackage

// [bench/brc_mst.sv]
// serial bus master model for the regulator control bench
`timescale 1ns/100ps
`default_nettype none
module brc_mst (
  input  wire logic clock,      // system clock
  input  wire logic line,       // resolved data line
  output logic      scl = 1'b1, // serial clock, idles high
  output logic      sda = 1'b1  // data drive, 1 releases
);
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // data moves one clock after scl falls, never while it is high
  // scl stays low six clocks: the slave answers five clocks after a fall
  task automatic bit_x(input logic b, output logic r);
    w(1);
    sda <= b;
    w(5);
    scl <= 1'b1;
    w(1);
    r = line;
    w(1);
    scl <= 1'b0;
  endtask
  task automatic start();
    w(1);
    sda <= 1'b1;
    w(5);
    scl <= 1'b1;
    w(4);
    sda <= 1'b0;
    w(4);
    scl <= 1'b0;
  endtask
  task automatic stop();
    w(1);
    sda <= 1'b0;
    w(5);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(m, k);
  endtask
endmodule // brc_mst
`default_nettype wire

// [bench/brc_top_tb_top.sv]
// self-checking bench for the buck regulator serial control block
`timescale 1ns/100ps
`default_nettype none
module brc_top_tb_top;
  import brc_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl, sda_m, sda_out, sda_oe, pg_out, pg_oe, sw_en, hs_off, dis_en, fpwm, hs;
  logic [20:0] tuv;
  brc_pins_t   p_in = 11'h701;
  brc_pins_t   pins;
  int          num_errors = 0;
  int          checks = 0;
  logic [31:0] seed = 32'h0000DDBD;
  always #50 clock = ~clock;
  // open drain: line is low when either side pulls
  always_comb
  begin
    pins = p_in;
    pins.scl = scl;
    pins.sda = sda_m & ~sda_oe;
  end
  brc_top #(.RETRY_CYCLES(40)) u_dut (.clock(clock), .rst_n(rst_n), .pins(pins), .sda_out(sda_out),
    .sda_oe(sda_oe), .power_ok_pin_out(pg_out), .power_ok_pin_oe(pg_oe), .switch_enable(sw_en),
    .high_side_off(hs_off), .discharge_en(dis_en), .forced_pwm(fpwm), .target_uv(tuv), .hs_mode(hs));
  brc_mst u_mst (.clock(clock), .line(pins.sda), .scl(scl), .sda(sda_m));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [20:0] exp_uv(input logic [5:0] c);
    return 21'(OFFSET_600_UV + int'(c) * STEP_10_UV);
  endfunction
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    u_mst.start();
    u_mst.xfer(8'hC0, 1'b1, r, k);
    chk("addr ack", 1'b0, k);
    u_mst.xfer(a, 1'b1, r, k);
    u_mst.xfer(d, 1'b1, r, k);
    chk("data ack", 1'b0, k);
    u_mst.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    u_mst.start();
    u_mst.xfer(8'hC0, 1'b1, d, k);
    u_mst.xfer(a, 1'b1, d, k);
    u_mst.start();
    u_mst.xfer(8'hC1, 1'b1, d, k);
    chk("read ack", 1'b0, k);
    u_mst.xfer(8'hFF, 1'b1, d, k);
    u_mst.stop();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    logic [7:0] d;
    logic [7:0] c;
    logic       k;
    u_mst.w(6);
    rst_n <= 1'b1;
    u_mst.w(10);
    rd(REG_REGULATION, d);
    chk("status", STATUS_REGULATING, d);
    chk("power_ok_pin", 1'b0, pg_oe);
    chk("od levels", 2'b00, {sda_out, pg_out});
    $display("status test done");
    repeat (6)
    begin
      c = {2'b10, 6'(rnd())};
      wr(REG_SETPOINT_LOW, c);
      rd(REG_SETPOINT_LOW, d);
      chk("setpoint", c, d);
      chk("target", exp_uv(c[5:0]), tuv);
    end
    p_in.setpoint_select_pin <= 1'b1;
    u_mst.w(120);
    chk("high target", exp_uv(6'h3C), tuv);
    chk("fpwm", 1'b1, fpwm);
    $display("setpoint test done");
    c = 8'(rnd());
    if (c[7:1] == 7'h60)
      c ^= 8'h02;
    u_mst.start();
    u_mst.xfer(c, 1'b1, d, k);
    chk("foreign nack", 1'b1, k);
    u_mst.start();
    u_mst.xfer(8'h0B, 1'b1, d, k);
    chk("code nack", 1'b1, k);
    chk("hs on", 1'b1, hs);
    u_mst.stop();
    u_mst.w(8);
    chk("hs off", 1'b0, hs);
    $display("address test done");
    p_in.hw_enable <= 1'b0;
    u_mst.w(10);
    chk("off power_ok_pin", 1'b1, pg_oe);
    chk("off switch", 1'b0, sw_en);
    chk("discharge", 1'b1, dis_en);
    p_in.hw_enable <= 1'b1;
    p_in.current_limit <= 1'b1;
    u_mst.w(10);
    chk("on switch", 1'b1, sw_en);
    chk("high side", 1'b1, hs_off);
    repeat (16)
    begin
      p_in.switch_cycle <= 1'b1;
      u_mst.w(4);
      p_in.switch_cycle <= 1'b0;
      u_mst.w(4);
    end
    u_mst.w(6);
    chk("retry off", 1'b0, sw_en);
    chk("retry power_ok_pin", 1'b1, pg_oe);
    p_in.current_limit <= 1'b0;
    u_mst.w(60);
    chk("restart", 1'b1, sw_en);
    $display("fault test done");
    p_in.output_reached <= 1'b0;
    wr(REG_SETPOINT_HIGH, 8'h90);
    chk("down switch", 1'b0, sw_en);
    chk("down hold", exp_uv(6'h3C), tuv);
    chk("down power_ok_pin", 1'b0, pg_oe);
    p_in.output_reached <= 1'b1;
    u_mst.w(10);
    chk("down done", exp_uv(6'h10), tuv);
    chk("down end", 1'b1, sw_en);
    $display("downward test done");
    p_in.input_overvoltage_guard <= 1'b1;
    u_mst.w(6 + rnd() % 12);
    chk("ovp spike", 1'b1, sw_en);
    p_in.input_overvoltage_guard <= 1'b0;
    p_in.soft_start <= 1'b1;
    u_mst.w(10);
    chk("soft power_ok_pin", 1'b1, pg_oe);
    p_in.soft_start <= 1'b0;
    for (int i = 4; i < 7; i++)
    begin
      p_in[i] <= 1'b1;
      u_mst.w(30);
      chk("fault switch", 1'b0, sw_en);
      chk("fault power_ok_pin", 1'b1, pg_oe);
      p_in[i] <= 1'b0;
      u_mst.w(10);
      chk("fault clear", 1'b1, sw_en);
    end
    $display("protection test done");
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule // brc_top_tb_top
`default_nettype wire
